// File: verilog/esm_pkg.sv
// shared constants, types and helpers for the eSPI master select block
package esm_pkg;

  // topology: number of attached slaves and select index width
  localparam int NUM_SLV = 2;
  localparam int SLV_W   = 1;
  localparam int IO_W    = 4;

  // timing: system clock and serial clock rates
  localparam int SYS_CLK_MHZ    = 100;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC  = (SCLK_PERIOD_NS * SYS_CLK_MHZ) / 2000;
  localparam int CNT_W          = 4;
  localparam logic [CNT_W-1:0] CNT_RISE = CNT_W'(SCLK_HALF_CYC);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(2 * SCLK_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_HALF_LAST = CNT_W'(SCLK_HALF_CYC - 1);

  // turn-around window length in serial clocks
  localparam logic [1:0] TAR_CLKS = 2'h2;

  // reset and idle levels of the link pins
  localparam logic [NUM_SLV-1:0] CS_IDLE  = {NUM_SLV{1'b1}};
  localparam logic [IO_W-1:0]    IO_HIGH  = {IO_W{1'b1}};
  localparam logic [7:0]         BYTE_RST = 8'h00;

  // one transaction request
  typedef struct packed {
    logic [SLV_W-1:0] target;   // slave to select
    logic             is_espi;  // 1: eSPI framing with turn-around, 0: plain SPI
    logic [7:0]       cmd_len;  // bytes sent by master, at least one
    logic [7:0]       rsp_len;  // bytes read back, may be zero
  } esm_req_t;

  // sequencer states
  typedef enum logic [2:0] {
    ESM_IDLE,
    ESM_SETUP,
    ESM_CMD,
    ESM_TAR,
    ESM_RSP,
    ESM_GAP
  } esm_state_t;

  // active-low one-hot select for a single slave
  function automatic logic [NUM_SLV-1:0] esm_cs_sel(input logic [SLV_W-1:0] target);
    logic [NUM_SLV-1:0] v;
    v = CS_IDLE;
    v[target] = 1'b0;
    return v;
  endfunction

endpackage

// File: verilog/esm_sync.sv
// two-flop synchroniser for pin inputs
module esm_sync #(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // asynchronous input and synchronised output
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q_sync
);

  logic [W-1:0] meta;

  // first stage is read only by the second
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta   <= RST_VAL;
      q_sync <= RST_VAL;
    end else begin
      meta   <= d_async;
      q_sync <= meta;
    end
  end

endmodule

// File: verilog/esm_top.sv
// eSPI master chip-select, clock and turn-around sequencer
// Notes on behaviour
// - With link reset released, only the master drives chip selects.
// - One master, one or more slaves; only this block selects and clocks.
// - Link reset sourced by slave or by master, as configured.
// - Clock and data lines shared; only the selected slave answers.
// - Each slave has its own chip select and alert, both handled here.
// - Channels are independent; no ordering is kept between them.
// - All link pins but a master-sourced reset pin released while link reset is asserted.
// - Turn-around is two clocks: drive data high, then release.
// - After link reset the link runs on a single data line.
module esm_top
  import esm_pkg::*;
(
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  // configuration
  input  wire logic                        rst_from_slave,
  input  wire logic                        link_rst_req,
  // request
  input  wire logic                        req_valid,
  input  wire esm_pkg::esm_req_t           req,
  output logic                             req_ready,
  // command byte stream
  input  wire logic [7:0]                  tx_data,
  output logic                             tx_take,
  // response byte stream and completion
  output logic [7:0]                       rx_data,
  output logic                             rx_valid,
  output logic                             done,
  // status
  output logic                             link_in_reset,
  output logic [esm_pkg::NUM_SLV-1:0]      alert_pend,
  // link pins
  output logic [esm_pkg::NUM_SLV-1:0]      cs_n_o,
  output logic [esm_pkg::NUM_SLV-1:0]      cs_n_oe,
  output logic                             sclk_o,
  output logic                             sclk_oe,
  input  wire logic [esm_pkg::IO_W-1:0]    io_i,
  output logic [esm_pkg::IO_W-1:0]         io_o,
  output logic [esm_pkg::IO_W-1:0]         io_oe,
  input  wire logic [esm_pkg::NUM_SLV-1:0] alert_n_i,
  input  wire logic                        lrst_n_i,
  output logic                             lrst_n_o,
  output logic                             lrst_n_oe
);
  import esm_pkg::*;

  localparam int SYN_W = NUM_SLV + IO_W + 1;

  // synchronised pins
  logic [SYN_W-1:0]   syn_q;
  logic [IO_W-1:0]    io_s;
  logic [NUM_SLV-1:0] alert_s;
  logic               lrst_s;

  // sequencer state
  esm_state_t         st,       next_st;
  esm_req_t           cur,      next_cur;
  logic [CNT_W-1:0]   cnt,      next_cnt;
  logic [2:0]         bitc,     next_bitc;
  logic [7:0]         bytec,    next_bytec;
  logic [1:0]         tarc,     next_tarc;
  logic [7:0]         shreg,    next_shreg;
  logic [NUM_SLV-1:0] next_cs_n_o;
  logic               next_sclk_o;
  logic [IO_W-1:0]    next_io_o,  next_io_oe;
  logic               next_tx_take, next_rx_valid, next_done, next_req_ready;
  logic [7:0]         next_rx_data;
  logic               link_rst;

  // link control state
  logic               dir_slave;
  logic               next_lrst_n_o, next_lrst_n_oe, next_link_in_reset;
  logic [NUM_SLV-1:0] next_alert_pend;
  logic               next_pin_oe;

  // pins from outside pass two flops first
  esm_sync #(
    .W       (SYN_W),
    .RST_VAL ({SYN_W{1'b1}})
  ) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .d_async ({lrst_n_i, alert_n_i, io_i}),
    .q_sync  (syn_q)
  );

  assign io_s    = syn_q[IO_W-1:0];
  assign alert_s = syn_q[IO_W +: NUM_SLV];
  assign lrst_s  = syn_q[SYN_W-1];

  // reset source: slave-driven level or our own driven level
  assign link_rst = dir_slave ? ~lrst_s : ~lrst_n_o;

  // reset-direction strap caught while system reset is held
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_slave <= rst_from_slave;
    end
  end

  // link reset pin, pin enables and alert status
  always_comb begin
    next_lrst_n_o      = ~link_rst_req;
    next_lrst_n_oe     = ~dir_slave;
    next_link_in_reset = link_rst;
    next_pin_oe        = ~link_rst;
    // alert counts only while that slave is not selected
    next_alert_pend    = ~alert_s & cs_n_o;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lrst_n_o      <= 1'b0;
      lrst_n_oe     <= 1'b0;
      link_in_reset <= 1'b1;
      cs_n_oe       <= '0;
      sclk_oe       <= 1'b0;
      alert_pend    <= '0;
    end else begin
      lrst_n_o      <= next_lrst_n_o;
      lrst_n_oe     <= next_lrst_n_oe;
      link_in_reset <= next_link_in_reset;
      cs_n_oe       <= {NUM_SLV{next_pin_oe}};
      sclk_oe       <= next_pin_oe;
      alert_pend    <= next_alert_pend;
    end
  end

  // transaction sequencer next state
  always_comb begin
    next_st        = st;
    next_cur       = cur;
    next_cnt       = cnt;
    next_bitc      = bitc;
    next_bytec     = bytec;
    next_tarc      = tarc;
    next_shreg     = shreg;
    next_cs_n_o    = cs_n_o;
    next_sclk_o    = 1'b0;
    next_io_o      = io_o;
    next_io_oe     = '0;
    next_tx_take   = 1'b0;
    next_rx_valid  = 1'b0;
    next_rx_data   = rx_data;
    next_done      = 1'b0;
    next_req_ready = 1'b0;
    case (st)
      ESM_IDLE: begin
        next_cs_n_o = CS_IDLE;
        if (req_valid && req_ready && !link_rst) begin
          next_cur     = req;
          next_cs_n_o  = esm_cs_sel(req.target);
          next_shreg   = tx_data;
          next_tx_take = 1'b1;
          next_cnt     = '0;
          next_bitc    = '0;
          next_bytec   = '0;
          next_st      = ESM_SETUP;
        end else begin
          next_req_ready = ~link_rst;
        end
      end
      ESM_SETUP: begin
        // clock held low while select falls; first bit launched
        next_io_o  = {IO_W{shreg[7]}};
        next_io_oe = {{(IO_W-1){1'b0}}, 1'b1};
        next_cnt   = cnt + 1'b1;
        if (cnt == CNT_HALF_LAST) begin
          next_cnt = '0;
          next_st  = ESM_CMD;
        end
      end
      ESM_CMD: begin
        // single-line output on data line 0
        next_sclk_o = (cnt >= CNT_RISE) && (cnt != CNT_LAST);
        next_io_oe  = {{(IO_W-1){1'b0}}, 1'b1};
        next_io_o   = {IO_W{shreg[7]}};
        next_cnt    = cnt + 1'b1;
        if (cnt == CNT_LAST) begin
          next_cnt   = '0;
          next_bitc  = bitc + 1'b1;
          next_shreg = {shreg[6:0], 1'b0};
          next_io_o  = {IO_W{shreg[6]}};
          if (bitc == 3'h7) begin
            next_bytec = bytec + 1'b1;
            if (bytec + 8'h01 >= cur.cmd_len) begin
              next_bytec = '0;
              next_tarc  = '0;
              next_io_o  = IO_HIGH;
              if (cur.is_espi) begin
                // all lines driven high from the end of the last command bit
                next_io_oe = IO_HIGH;
                next_st    = ESM_TAR;
              end else if (cur.rsp_len != 8'h00) begin
                next_io_oe = '0;
                next_st    = ESM_RSP;
              end else begin
                next_io_oe  = '0;
                next_cs_n_o = CS_IDLE;
                next_st     = ESM_GAP;
              end
            end else begin
              next_shreg   = tx_data;
              next_io_o    = {IO_W{tx_data[7]}};
              next_tx_take = 1'b1;
            end
          end
        end
      end
      ESM_TAR: begin
        // first clock all lines high, second clock released
        next_sclk_o = (cnt >= CNT_RISE) && (cnt != CNT_LAST);
        next_io_o   = IO_HIGH;
        next_io_oe  = (tarc == 2'h0) ? IO_HIGH : '0;
        next_cnt    = cnt + 1'b1;
        if (cnt == CNT_LAST) begin
          next_cnt   = '0;
          next_tarc  = tarc + 1'b1;
          next_io_oe = '0;
          if (tarc + 2'h1 == TAR_CLKS) begin
            if (cur.rsp_len != 8'h00) begin
              next_st = ESM_RSP;
            end else begin
              next_cs_n_o = CS_IDLE;
              next_st     = ESM_GAP;
            end
          end
        end
      end
      ESM_RSP: begin
        // selected slave answers on data line 1
        next_sclk_o = (cnt >= CNT_RISE) && (cnt != CNT_LAST);
        next_cnt    = cnt + 1'b1;
        if (cnt == CNT_RISE) begin
          next_shreg = {shreg[6:0], io_s[1]};
          if (bitc == 3'h7) begin
            next_rx_data  = {shreg[6:0], io_s[1]};
            next_rx_valid = 1'b1;
          end
        end
        if (cnt == CNT_LAST) begin
          next_cnt  = '0;
          next_bitc = bitc + 1'b1;
          if (bitc == 3'h7) begin
            next_bytec = bytec + 1'b1;
            if (bytec + 8'h01 >= cur.rsp_len) begin
              next_cs_n_o = CS_IDLE;
              next_st     = ESM_GAP;
            end
          end
        end
      end
      ESM_GAP: begin
        // select high for half a clock before the next request
        next_cs_n_o = CS_IDLE;
        next_cnt    = cnt + 1'b1;
        if (cnt == CNT_HALF_LAST) begin
          next_cnt       = '0;
          next_done      = 1'b1;
          next_req_ready = ~link_rst;
          next_st        = ESM_IDLE;
        end
      end
      default: begin
        next_st     = ESM_IDLE;
        next_cs_n_o = CS_IDLE;
      end
    endcase
    // link reset aborts any transfer and releases the lines
    if (link_rst) begin
      next_st        = ESM_IDLE;
      next_cs_n_o    = CS_IDLE;
      next_sclk_o    = 1'b0;
      next_io_oe     = '0;
      next_req_ready = 1'b0;
      next_tx_take   = 1'b0;
      next_rx_valid  = 1'b0;
      next_done      = 1'b0;
    end
  end

  // sequencer registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st        <= ESM_IDLE;
      cur       <= '0;
      cnt       <= '0;
      bitc      <= '0;
      bytec     <= '0;
      tarc      <= '0;
      shreg     <= BYTE_RST;
      cs_n_o    <= CS_IDLE;
      sclk_o    <= 1'b0;
      io_o      <= IO_HIGH;
      io_oe     <= '0;
      tx_take   <= 1'b0;
      rx_valid  <= 1'b0;
      rx_data   <= BYTE_RST;
      done      <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      st        <= next_st;
      cur       <= next_cur;
      cnt       <= next_cnt;
      bitc      <= next_bitc;
      bytec     <= next_bytec;
      tarc      <= next_tarc;
      shreg     <= next_shreg;
      cs_n_o    <= next_cs_n_o;
      sclk_o    <= next_sclk_o;
      io_o      <= next_io_o;
      io_oe     <= next_io_oe;
      tx_take   <= next_tx_take;
      rx_valid  <= next_rx_valid;
      rx_data   <= next_rx_data;
      done      <= next_done;
      req_ready <= next_req_ready;
    end
  end

endmodule

// File: sim/esm_top_sva.sv
// assertion checker for the eSPI master select sequencer
module esm_top_chk (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  // status
  input wire logic       link_in_reset,
  input wire logic       req_ready,
  input wire logic [1:0] alert_n_i,
  input wire logic [1:0] alert_pend,
  // link pins
  input wire logic [1:0] cs_n_o,
  input wire logic [1:0] cs_n_oe,
  input wire logic       sclk_o,
  input wire logic       sclk_oe,
  input wire logic [3:0] io_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  logic [4:0] hi_cnt;
  logic [4:0] next_hi_cnt;
  // cycles spent driving every data line
  always_comb begin
    next_hi_cnt = (io_oe == 4'hf) ? hi_cnt + 5'h01 : 5'h00;
  end
  always_ff @(posedge clk_sys) begin
    hi_cnt <= sys_rst ? 5'h00 : next_hi_cnt;
  end
  // end of the drive-high turn-around step
  sequence tar_end_s;
    $fell(io_oe == 4'hf);
  endsequence
  // link settled out of reset
  sequence link_up_s;
    !link_in_reset && !$fell(link_in_reset);
  endsequence
  one_select_a: assert property ($onehot0(~cs_n_o))
    else $error("two selects low");
  pins_float_a: assert property (link_in_reset [*3] |-> !(|{cs_n_oe, sclk_oe, io_oe}))
    else $error("pin driven in link reset");
  only_master_a: assert property (link_up_s |-> &{cs_n_oe, sclk_oe})
    else $error("select or clock not driven");
  cs_clk_low_a: assert property (|($past(cs_n_o) & ~cs_n_o) |-> !sclk_o)
    else $error("select fell with clock high");
  tar_len_a: assert property (tar_end_s |-> io_oe == 4'h0 && hi_cnt == 5'h10)
    else $error("turn-around not one clock high then released");
  single_line_a: assert property (io_oe != 4'hf |-> io_oe[3:1] == 3'h0)
    else $error("extra data line driven");
  alert_quiet_a: assert property ((&alert_n_i) [*4] |-> alert_pend == 2'h0)
    else $error("alert pending with lines high");
  idle_desel_a: assert property (req_ready |-> cs_n_o == 2'h3 && !sclk_o)
    else $error("select or clock active while idle");
endmodule

// File: sim/esm_slave_model.sv
// behavioural slave: one reply byte on data line 1, alert on request
module esm_slave_model #(
  parameter logic [7:0] RESP = 8'ha5
) (
  // link side, select and clock are inputs only
  input  wire logic       cs_n,
  input  wire logic       sclk,
  output logic            io1_d,
  output logic            io1_oe,
  output logic            alert_n,
  // bench control
  input  wire logic       alert_req,
  input  wire logic [7:0] resp_at
);
  timeunit 1ns;
  timeprecision 100ps;
  int rises = 0;
  initial io1_oe = 1'b0;
  // count clock rises within a frame
  always @(posedge sclk or posedge cs_n) begin
    if (cs_n)
      rises <= 0;
    else
      rises <= rises + 1;
  end
  // reply bits after a falling clock, only while selected
  always @(negedge sclk or posedge cs_n) begin
    if (cs_n || rises < resp_at || rises > resp_at + 7)
      io1_oe <= 1'b0;
    else begin
      io1_oe <= 1'b1;
      io1_d  <= RESP[7 - (rises - resp_at)];
    end
  end
  // alert pulled low only while deselected
  assign alert_n = ~(alert_req & cs_n);
endmodule

// File: sim/tb_top.sv
// self-checking bench for the eSPI master select sequencer
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
`define WAIT(c, nm) for (int w = 0; !(c); w++) begin if (w == 3000) begin n_fail++; \
  $display("Error %s expected 1 seen 0", nm); break; end step(1); end
module tb_top
  import esm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // stimulus
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        rst_from_slave = 1'b0;
  logic        link_rst_req = 1'b1;
  logic        req_valid = 1'b0;
  logic        lrst_drv = 1'b1;
  esm_req_t    req = '0;
  logic [7:0]  tx_data = 8'h00;
  logic [7:0]  resp_at = 8'h00;
  logic [1:0]  alert_req = 2'h0;
  // design outputs and wire levels
  logic        tx_take, rx_valid, done, link_in_reset, req_ready, sclk_o, sclk_oe;
  logic        lrst_n_o, lrst_n_oe, lrst_n_i, sclk, io1;
  logic [7:0]  rx_data, rxb, txb [2];
  logic [1:0]  alert_pend, cs_n_o, cs_n_oe, cs_seen;
  wire  [1:0]  s_d, s_oe, alert_n_i;
  logic [3:0]  io_o, io_oe, io_i, pin;
  logic [15:0] mosi;
  int          n_fail = 0, n_compared = 0, tarc, tx_idx, n_done = 0;
  // pull-ups on selects, data and reset, pull-down on the clock
  assign pin = (io_o & io_oe) | ~io_oe;
  assign io1 = io_oe[1] ? io_o[1] : s_oe[0] ? s_d[0] : s_oe[1] ? s_d[1] : 1'b1;
  assign io_i = {pin[3:2], io1, pin[0]};
  assign sclk = sclk_oe & sclk_o;
  assign lrst_n_i = lrst_n_oe ? lrst_n_o : lrst_drv;
  esm_top dut (.clk_sys, .sys_rst, .rst_from_slave, .link_rst_req, .req_valid, .req, .req_ready,
    .tx_data, .tx_take, .rx_data, .rx_valid, .done, .link_in_reset, .alert_pend, .cs_n_o,
    .cs_n_oe, .sclk_o, .sclk_oe, .io_i, .io_o, .io_oe, .alert_n_i, .lrst_n_i, .lrst_n_o,
    .lrst_n_oe);
  esm_slave_model #(.RESP(8'ha5)) u_s0 (.cs_n(cs_n_o[0] | ~cs_n_oe[0]), .sclk, .io1_d(s_d[0]),
    .io1_oe(s_oe[0]), .alert_n(alert_n_i[0]), .alert_req(alert_req[0]), .resp_at);
  esm_slave_model #(.RESP(8'h3c)) u_s1 (.cs_n(cs_n_o[1] | ~cs_n_oe[1]), .sclk, .io1_d(s_d[1]),
    .io1_oe(s_oe[1]), .alert_n(alert_n_i[1]), .alert_req(alert_req[1]), .resp_at);
  initial forever #5 clk_sys = ~clk_sys;
  // watch command bits and drive-high turn-around clocks
  always @(posedge sclk) begin
    if (io_oe === 4'h1) mosi = {mosi[14:0], io_o[0]};
    if (io_oe === 4'hf && io_o === 4'hf) tarc++;
  end
  // watch selects, replies, completions; feed the next command byte
  always @(posedge clk_sys) begin
    cs_seen = cs_seen | ~cs_n_o;
    if (rx_valid === 1'b1) rxb = rx_data;
    if (done === 1'b1) n_done++;
    if (tx_take === 1'b1) begin
      #1 tx_idx++;
      tx_data = txb[tx_idx % 2];
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic do_reset(input logic from_slave);
    sys_rst = 1'b1;
    rst_from_slave = from_slave;
    step(20);
    sys_rst = 1'b0;
  endtask
  task automatic send_req(input logic tgt, input logic esp, input int nb);
    req = '{tgt, esp, 8'(nb), 8'h01};
    req_valid = 1'b1;
    `WAIT(req_ready === 1'b1, "req_ready")
    step(1);
    req_valid = 1'b0;
  endtask
  task automatic t_link_up;
    step(5);
    `CHK("enables in reset", 7'h00, {cs_n_oe, sclk_oe, io_oe})
    `CHK("reset drive", 3'h4, {lrst_n_oe, lrst_n_o, req_ready})
    link_rst_req = 1'b0;
    `WAIT(req_ready === 1'b1, "req_ready")
    step(1);
    `CHK("idle pins", 6'h3d, {cs_n_o, cs_n_oe, sclk_o, sclk_oe})
    $display("test link_up done");
  endtask
  task automatic xfer(input logic tgt, input logic esp, input logic [15:0] cmd, input int nb,
                      input logic [7:0] exp_rx);
    mosi = 16'h0000;
    tarc = 0;
    cs_seen = 2'h0;
    tx_idx = 0;
    rxb = 8'h00;
    txb[0] = (nb == 2) ? cmd[15:8] : cmd[7:0];
    txb[1] = cmd[7:0];
    tx_data = txb[0];
    resp_at = 8'(nb * 8 + (esp ? 2 : 0));
    send_req(tgt, esp, nb);
    `WAIT(done === 1'b1, "done")
    `CHK("command bits", cmd, mosi)
    `CHK("turn-around clocks", esp ? 1 : 0, tarc)
    `CHK("selects used", 2'h1 << tgt, cs_seen)
    `CHK("reply byte", exp_rx, rxb)
    $display("test xfer to slave %0d done", tgt);
  endtask
  task automatic t_alert;
    for (int i = 0; i < 2; i++) begin
      alert_req = 2'h1 << i;
      step(6);
      `CHK("alert pending", 2'h1 << i, alert_pend)
      alert_req = 2'h0;
      step(6);
      `CHK("alert cleared", 2'h0, alert_pend)
    end
    $display("test alert done");
  endtask
  task automatic t_abort;
    int d;
    d = n_done;
    send_req(1'b0, 1'b1, 1);
    step(40);
    link_rst_req = 1'b1;
    `WAIT(link_in_reset === 1'b1, "link_in_reset")
    step(2);
    `CHK("enables in abort", 7'h00, {cs_n_oe, sclk_oe, io_oe})
    link_rst_req = 1'b0;
    `WAIT(req_ready === 1'b1, "req_ready")
    `CHK("done after abort", d, n_done)
    $display("test abort done");
  endtask
  task automatic t_slave_rst;
    lrst_drv = 1'b0;
    do_reset(1'b1);
    step(5);
    `CHK("slave reset held", 4'h8, {link_in_reset, lrst_n_oe, cs_n_oe})
    lrst_drv = 1'b1;
    `WAIT(req_ready === 1'b1, "req_ready")
    xfer(1'b0, 1'b1, 16'h0081, 1, 8'ha5);
    $display("test slave_rst done");
  endtask
  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #1;
    do_reset(1'b0);
    t_link_up();
    xfer(1'b1, 1'b1, 16'h9c5a, 2, 8'h3c);
    xfer(1'b0, 1'b0, 16'h00c3, 1, 8'ha5);
    t_alert();
    t_abort();
    t_slave_rst();
    give_verdict();
  end
  // watchdog well past the expected run of just over a thousand cycles
  initial begin
    #200us;
    n_fail++;
    give_verdict();
  end
endmodule
bind esm_top esm_top_chk u_chk (.clk_sys, .sys_rst, .link_in_reset, .req_ready, .alert_n_i,
  .alert_pend, .cs_n_o, .cs_n_oe, .sclk_o, .sclk_oe, .io_oe);
